//--- ccc_axil_slave.sv
// axi4-lite slave front end, one write and one read in flight
`timescale 1ns/100ps
`default_nettype none

module ccc_axil_slave #(
  parameter int ADDR_W = 4
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              arst_n,
  // write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // register side
  output logic                   wr_en,
  output logic      [ADDR_W-1:0] wr_addr,
  output logic      [31:0]       wr_data,
  output logic      [3:0]        wr_strb,
  input  wire logic              wr_hit,
  output logic      [ADDR_W-1:0] rd_addr,
  input  wire logic [31:0]       rd_data,
  input  wire logic              rd_hit
);

  typedef struct packed {
    logic              aw_have;
    logic              w_have;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } ccc_axil_s;

  ccc_axil_s q_r;
  ccc_axil_s q_nxt;

  // ======================================
  // channel handling
  always_comb begin
    q_nxt = q_r;
    wr_en = 1'b0;
    if (q_r.bvalid && s_axi_bready) begin
      q_nxt.bvalid = 1'b0;
    end
    if (q_r.rvalid && s_axi_rready) begin
      q_nxt.rvalid = 1'b0;
    end
    if (s_axi_awvalid && q_r.awready) begin
      q_nxt.aw_have = 1'b1;
      q_nxt.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && q_r.wready) begin
      q_nxt.w_have = 1'b1;
      q_nxt.wdata  = s_axi_wdata;
      q_nxt.wstrb  = s_axi_wstrb;
    end
    // commit only once both halves are held
    if (q_r.aw_have && q_r.w_have && !q_r.bvalid) begin
      wr_en         = 1'b1;
      q_nxt.aw_have = 1'b0;
      q_nxt.w_have  = 1'b0;
      q_nxt.bvalid  = 1'b1;
      q_nxt.bresp   = wr_hit ? ccc_pkg::CCC_RESP_OKAY : ccc_pkg::CCC_RESP_SLVERR;
    end
    if (s_axi_arvalid && q_r.arready) begin
      q_nxt.rvalid = 1'b1;
      q_nxt.rdata  = rd_hit ? rd_data : 32'h0000_0000;
      q_nxt.rresp  = rd_hit ? ccc_pkg::CCC_RESP_OKAY : ccc_pkg::CCC_RESP_SLVERR;
    end
    // ready held low while a transfer or its answer is pending
    q_nxt.awready = !q_nxt.aw_have && !q_nxt.bvalid;
    q_nxt.wready  = !q_nxt.w_have && !q_nxt.bvalid;
    q_nxt.arready = !q_nxt.rvalid;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q_r         <= '0;
      q_r.awready <= 1'b1;
      q_r.wready  <= 1'b1;
      q_r.arready <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign s_axi_awready = q_r.awready;
  assign s_axi_wready  = q_r.wready;
  assign s_axi_bvalid  = q_r.bvalid;
  assign s_axi_bresp   = q_r.bresp;
  assign s_axi_arready = q_r.arready;
  assign s_axi_rvalid  = q_r.rvalid;
  assign s_axi_rdata   = q_r.rdata;
  assign s_axi_rresp   = q_r.rresp;
  assign wr_addr       = q_r.awaddr;
  assign wr_data       = q_r.wdata;
  assign wr_strb       = q_r.wstrb;
  assign rd_addr       = s_axi_araddr;

endmodule : ccc_axil_slave

`default_nettype wire

//--- ccc_map.svh
// register offsets, field positions and reset values of the core control block
`ifndef CCC_MAP_SVH
`define CCC_MAP_SVH

// ======================================
// register map
`define CCC_CTRL_IDX   0
`define CCC_CTRL_OFF   32'h0000_0000

// ======================================
// fields of the core control register
`define CCC_FLAG_BIT   3
`define CCC_WIN_BIT    2
`define CCC_CTRL_RST   16'h0000
`define CCC_IPL_RST    4'h0

`endif

//--- ccc_pkg.sv
// shared types of the core control block
`default_nettype none

package ccc_pkg;

  // ======================================
  // bus response codes
  typedef enum logic [1:0] {
    CCC_RESP_OKAY   = 2'b00,
    CCC_RESP_SLVERR = 2'b10
  } ccc_resp_e;

  // ======================================
  // state of the top module
  typedef struct packed {
    logic [3:0] ipl;
    logic       win;
    logic       irq_take;
  } ccc_top_s;

endpackage : ccc_pkg

`default_nettype wire

//--- ccc_psv_map.sv
// program-space window mapper for data reads
`timescale 1ns/100ps
`default_nettype none

module ccc_psv_map #(
  parameter int ADDR_W = 16
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              arst_n,
  // control
  input  wire logic              win_en,
  // data side
  input  wire logic [ADDR_W-1:0] data_addr,
  input  wire logic              data_rd,
  // program side
  output logic                   prog_rd,
  output logic      [ADDR_W-2:0] prog_addr
);

  typedef struct packed {
    logic              rd;
    logic [ADDR_W-2:0] addr;
  } ccc_psv_s;

  ccc_psv_s q_r;
  ccc_psv_s q_nxt;

  // ======================================
  // upper half of data space maps onto program space
  always_comb begin
    q_nxt      = q_r;
    q_nxt.rd   = win_en && data_rd && data_addr[ADDR_W-1];
    q_nxt.addr = data_addr[ADDR_W-2:0];
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign prog_rd   = q_r.rd;
  assign prog_addr = q_r.addr;

endmodule : ccc_psv_map

`default_nettype wire

//--- ccc_top.sv
// cpu core control register with priority status and program-space window
//
// Summary of operation
// - unused bits read zero, ignore writes
// - bit 3 reads one when priority exceeds seven
// - flag clearable, never set by software, resets zero
// - bit 2 window enable, read/write, resets zero
// - enabled window maps program memory into data space
// - flag set blocks all user interrupts
//
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "ccc_map.svh"

module ccc_top #(
  parameter int ADDR_W = 4,
  parameter int DADR_W = 16
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              arst_n,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // axi4-lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // core priority level
  input  wire logic              cpu_ipl_load,
  input  wire logic [3:0]        cpu_ipl_value,
  output logic      [3:0]        cpu_ipl_level,
  output logic                   priority_above_seven_flag,
  // user interrupts
  input  wire logic              user_irq_req,
  input  wire logic [2:0]        user_irq_prio,
  output logic                   user_irq_take,
  // program-space window
  output logic                   program_space_window_enable,
  input  wire logic [DADR_W-1:0] data_addr,
  input  wire logic              data_rd,
  output logic                   prog_rd,
  output logic      [DADR_W-2:0] prog_addr
);

  ccc_pkg::ccc_top_s q_r;
  ccc_pkg::ccc_top_s q_nxt;

  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              wr_hit;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0]       rd_data;
  logic              rd_hit;
  logic [15:0]       ctrl_view;
  logic              ctrl_wr;

  // ======================================
  // bus front end
  ccc_axil_slave #(
    .ADDR_W (ADDR_W)
  ) u_bus (
    .clock         (clock),
    .arst_n        (arst_n),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_hit        (wr_hit),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_hit        (rd_hit)
  );

  // ======================================
  // decode and read view
  assign wr_hit  = wr_addr[ADDR_W-1:2] == (ADDR_W-2)'(`CCC_CTRL_IDX);
  assign rd_hit  = rd_addr[ADDR_W-1:2] == (ADDR_W-2)'(`CCC_CTRL_IDX);
  // both live fields sit in byte lane 0
  assign ctrl_wr = wr_en && wr_hit && wr_strb[0];

  always_comb begin
    ctrl_view               = `CCC_CTRL_RST;
    ctrl_view[`CCC_FLAG_BIT] = q_r.ipl[3];
    ctrl_view[`CCC_WIN_BIT]  = q_r.win;
  end

  assign rd_data = {16'h0000, ctrl_view};

  // ======================================
  // control state
  always_comb begin
    q_nxt = q_r;
    if (ctrl_wr) begin
      q_nxt.win = wr_data[`CCC_WIN_BIT];
      // writing zero clears; writing one has no effect
      if (!wr_data[`CCC_FLAG_BIT]) begin
        q_nxt.ipl[3] = 1'b0;
      end
    end
    // core load wins over a software clear in the same cycle
    if (cpu_ipl_load) begin
      q_nxt.ipl = cpu_ipl_value;
    end
    q_nxt.irq_take = user_irq_req && !q_r.ipl[3] && (user_irq_prio > q_r.ipl[2:0]);
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q_r     <= '0;
      q_r.ipl <= `CCC_IPL_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign cpu_ipl_level               = q_r.ipl;
  assign priority_above_seven_flag   = q_r.ipl[3];
  assign user_irq_take               = q_r.irq_take;
  assign program_space_window_enable = q_r.win;

  // ======================================
  // program-space window
  ccc_psv_map #(
    .ADDR_W (DADR_W)
  ) u_psv (
    .clock     (clock),
    .arst_n    (arst_n),
    .win_en    (q_r.win),
    .data_addr (data_addr),
    .data_rd   (data_rd),
    .prog_rd   (prog_rd),
    .prog_addr (prog_addr)
  );

  // ======================================
  // assertions
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready && rd_hit;
  endsequence

  sequence s_ctrl_wr;
    wr_en && wr_hit && wr_strb[0];
  endsequence

  sequence s_map_req;
    q_r.win && data_rd && data_addr[DADR_W-1];
  endsequence

  // writes that must leave the register untouched
  sequence s_noop_wr;
    wr_en && wr_hit && !wr_strb[0];
  endsequence

  sequence s_miss_wr;
    wr_en && !wr_hit;
  endsequence

  sequence s_irq_ok;
    user_irq_req && !priority_above_seven_flag && (user_irq_prio > cpu_ipl_level[2:0]);
  endsequence

  AST_RD_RESERVED_ZERO: assert property (
    (s_axi_rvalid && s_axi_rresp == ccc_pkg::CCC_RESP_OKAY)
      |-> (s_axi_rdata[31:4] == 28'h0 && s_axi_rdata[1:0] == 2'b00))
    else $error("reserved control bits read nonzero");

  AST_RD_FLAG_LEVEL: assert property (
    s_ar_take |=> (s_axi_rdata[`CCC_FLAG_BIT] == ($past(cpu_ipl_level) > 4'h7)))
    else $error("flag readback disagrees with priority level");

  AST_FLAG_NO_SW_SET: assert property (
    (!q_r.ipl[3] && !cpu_ipl_load) |=> !priority_above_seven_flag)
    else $error("flag set without a core load");

  AST_RESET_VALUES: assert property (
    $rose(arst_n) |-> (!priority_above_seven_flag && !program_space_window_enable))
    else $error("control bits not zero after reset");

  AST_WIN_WRITE: assert property (
    s_ctrl_wr ##1 s_axi_bvalid |-> program_space_window_enable == $past(wr_data[`CCC_WIN_BIT]))
    else $error("window enable did not take written value");

  AST_WIN_MAP: assert property (
    s_map_req |=> (prog_rd && prog_addr == $past(data_addr[DADR_W-2:0])))
    else $error("enabled window did not map program memory");

  AST_WIN_GATED: assert property (
    prog_rd |-> $past(program_space_window_enable))
    else $error("program read while window disabled");

  AST_IRQ_BLOCKED: assert property (
    priority_above_seven_flag |=> !user_irq_take)
    else $error("user interrupt taken while flag set");

  AST_CLEAR_LOWERS: assert property (
    (s_ctrl_wr and (!wr_data[`CCC_FLAG_BIT] && !cpu_ipl_load))
      |=> (!priority_above_seven_flag && cpu_ipl_level[2:0] == $past(cpu_ipl_level[2:0])))
    else $error("software clear did not lower priority");

  AST_LOAD_WINS: assert property (
    cpu_ipl_load |=> cpu_ipl_level == $past(cpu_ipl_value))
    else $error("core priority load lost");

  // ======================================
  // readback, hold, refusal, load, interrupt and reset checks
  AST_RD_WIN_LEVEL: assert property (
    s_ar_take
      |=> (s_axi_rdata[`CCC_WIN_BIT] == $past(program_space_window_enable)))
    else $error("window enable readback wrong");

  AST_WIN_HOLD: assert property (
    !(wr_en && wr_hit && wr_strb[0])
      |=> $stable(program_space_window_enable))
    else $error("window enable moved without a write");

  AST_STRB_IGNORED: assert property (
    (s_noop_wr and !cpu_ipl_load)
      |=> ($stable(program_space_window_enable) && $stable(cpu_ipl_level)))
    else $error("write with lane 0 off changed the register");

  AST_MISS_WR_IGNORED: assert property (
    (s_miss_wr and !cpu_ipl_load)
      |=> ($stable(program_space_window_enable) && $stable(cpu_ipl_level)))
    else $error("unmapped write changed the register");

  AST_MISS_RD_ZERO: assert property (
    (s_axi_rvalid && s_axi_rresp == ccc_pkg::CCC_RESP_SLVERR)
      |-> (s_axi_rdata == 32'h0000_0000))
    else $error("unmapped read returned nonzero data");

  AST_LEVEL_HOLD: assert property (
    (!cpu_ipl_load && !wr_en)
      |=> $stable(cpu_ipl_level))
    else $error("priority level moved with no load or clear");

  AST_LOAD_SETS_FLAG: assert property (
    (cpu_ipl_load && cpu_ipl_value[3])
      |=> priority_above_seven_flag)
    else $error("load above seven did not set flag");

  AST_LOAD_DROPS_FLAG: assert property (
    (cpu_ipl_load && !cpu_ipl_value[3])
      |=> !priority_above_seven_flag)
    else $error("load of seven or less left flag set");

  AST_IRQ_ACCEPT: assert property (
    s_irq_ok
      |=> user_irq_take)
    else $error("eligible user interrupt not taken");

  AST_IRQ_IDLE: assert property (
    !user_irq_req
      |=> !user_irq_take)
    else $error("user interrupt taken with no request");

  AST_MAP_LOW_HALF: assert property (
    (data_rd && !data_addr[DADR_W-1])
      |=> !prog_rd)
    else $error("lower data half reached program memory");

  AST_RESET_LEVEL: assert property (
    $rose(arst_n)
      |-> (cpu_ipl_level == `CCC_IPL_RST && !user_irq_take && !prog_rd))
    else $error("priority state not cleared by reset");

endmodule : ccc_top

`default_nettype wire

//--- tb.sv
// self-checking bench for the core control register block
`timescale 1ns/100ps
`default_nettype none

module tb;
  // ======================================
  // design signals
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'b0;
  logic [3:0]  s_axi_araddr = 4'h0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'b0;
  logic        cpu_ipl_load = 1'b0;
  logic [3:0]  cpu_ipl_value = 4'h0;
  logic [3:0]  cpu_ipl_level;
  logic        priority_above_seven_flag;
  logic        user_irq_req = 1'b0;
  logic [2:0]  user_irq_prio = 3'h0;
  logic        user_irq_take;
  logic        program_space_window_enable;
  logic [15:0] data_addr = 16'h0;
  logic        data_rd = 1'b0;
  logic        prog_rd;
  logic [14:0] prog_addr;
  int          fail_count = 0;
  int          n_compared = 0;
  int          cyc = 0;

  always #4 clock = ~clock;

  ccc_top i_dut (
    .clock(clock), .arst_n(arst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .cpu_ipl_load(cpu_ipl_load), .cpu_ipl_value(cpu_ipl_value),
    .cpu_ipl_level(cpu_ipl_level), .priority_above_seven_flag(priority_above_seven_flag),
    .user_irq_req(user_irq_req), .user_irq_prio(user_irq_prio), .user_irq_take(user_irq_take),
    .program_space_window_enable(program_space_window_enable),
    .data_addr(data_addr), .data_rd(data_rd), .prog_rd(prog_rd), .prog_addr(prog_addr)
  );

  // ======================================
  // shared helpers
  task automatic test_done;
    if (fail_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  // a hang is cut short well past the roughly 120 cycles the run needs
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask : chk

  // called just after a rising edge; address and data offered together
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    // idle edge: a following call must not re-raise a strobe in the same step
    @(posedge clock);
  endtask : axw

  task automatic axr(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", ed, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    @(posedge clock);
  endtask : axr

  task automatic ipl_load(input logic [3:0] v);
    cpu_ipl_load  <= 1'b1;
    cpu_ipl_value <= v;
    @(posedge clock);
    cpu_ipl_load <= 1'b0;
    @(posedge clock);
    chk("cpu_ipl_level", {28'h0, v}, {28'h0, cpu_ipl_level});
    chk("flag", {31'h0, v[3]}, {31'h0, priority_above_seven_flag});
  endtask : ipl_load

  task automatic irq_try(input logic [2:0] p, input logic e);
    user_irq_req  <= 1'b1;
    user_irq_prio <= p;
    @(posedge clock);
    @(posedge clock);
    user_irq_req <= 1'b0;
    chk("user_irq_take", {31'h0, e}, {31'h0, user_irq_take});
    @(posedge clock);
  endtask : irq_try

  task automatic win_try(input logic [15:0] a, input logic e);
    data_rd   <= 1'b1;
    data_addr <= a;
    @(posedge clock);
    data_rd <= 1'b0;
    @(posedge clock);
    chk("prog_rd", {31'h0, e}, {31'h0, prog_rd});
    if (e) chk("prog_addr", {17'h0, a[14:0]}, {17'h0, prog_addr});
    @(posedge clock);
  endtask : win_try

  // ======================================
  // scenarios
  task automatic t_reset;
    chk("flag", 32'h0, {31'h0, priority_above_seven_flag});
    chk("enable", 32'h0, {31'h0, program_space_window_enable});
    axr(4'h0, 32'h0, 2'b00);
  endtask : t_reset

  task automatic t_mask;
    axw(4'h0, 32'hffff_ffff, 2'b00);
    axr(4'h0, 32'h0000_0004, 2'b00);
    chk("enable", 32'h1, {31'h0, program_space_window_enable});
    axw(4'h0, 32'h0000_0000, 2'b00);
    axr(4'h0, 32'h0000_0000, 2'b00);
  endtask : t_mask

  task automatic t_flag;
    ipl_load(4'h7);
    irq_try(3'h7, 1'b0);
    ipl_load(4'h8);
    axr(4'h0, 32'h0000_0008, 2'b00);
    irq_try(3'h7, 1'b0);
    ipl_load(4'h9);
    axw(4'h0, 32'h0000_0004, 2'b00);
    axr(4'h0, 32'h0000_0004, 2'b00);
    chk("cpu_ipl_level", 32'h1, {28'h0, cpu_ipl_level});
    irq_try(3'h7, 1'b1);
    irq_try(3'h1, 1'b0);
    axw(4'h0, 32'h0000_0000, 2'b00);
  endtask : t_flag

  task automatic t_window;
    win_try(16'h8123, 1'b0);
    axw(4'h0, 32'h0000_0004, 2'b00);
    win_try(16'h8123, 1'b1);
    win_try(16'hfffe, 1'b1);
    win_try(16'h0123, 1'b0);
    axw(4'h0, 32'h0000_0000, 2'b00);
    win_try(16'h8001, 1'b0);
  endtask : t_window

  // unmapped words are refused and leave the register alone
  task automatic t_unmapped;
    axw(4'h4, 32'h0000_0004, 2'b10);
    axr(4'h8, 32'h0000_0000, 2'b10);
    axr(4'h0, 32'h0000_0000, 2'b00);
  endtask : t_unmapped

  // lane 0 strobe off: answered, but nothing changes
  task automatic t_strobe;
    s_axi_wstrb <= 4'he;
    axw(4'h0, 32'h0000_0004, 2'b00);
    s_axi_wstrb <= 4'hf;
    axr(4'h0, 32'h0000_0000, 2'b00);
    chk("enable", 32'h0, {31'h0, program_space_window_enable});
  endtask : t_strobe

  // reset in mid-run drops both live bits back to zero
  task automatic t_reset_mid;
    axw(4'h0, 32'h0000_0004, 2'b00);
    ipl_load(4'hc);
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    chk("flag", 32'h0, {31'h0, priority_above_seven_flag});
    chk("enable", 32'h0, {31'h0, program_space_window_enable});
    chk("cpu_ipl_level", 32'h0, {28'h0, cpu_ipl_level});
    axr(4'h0, 32'h0000_0000, 2'b00);
  endtask : t_reset_mid

  initial begin
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    t_reset();
    t_mask();
    t_flag();
    t_window();
    t_unmapped();
    t_strobe();
    t_reset_mid();
    test_done();
  end
endmodule : tb

`default_nettype wire
